// ### inc/oscsel_pkg.sv
// Constants and encodings for the oscillator source select block
// Notes on behaviour
// - Boot clock mode from two-bit config field
// - External clock frequency must match chosen power mode
// - External mode runs with no start-up delay
// - Stopped external clock freezes state, resumes intact
// - PLL on if config bit set, or run-time bit set outside select 1x
// - Select 00 switches to configured source
// - Select may switch to internal block at run-time
// - Internal mode: input pin is GPIO, output per config
// - High source 16 MHz derived from medium source
// - High source enabled by select and mode
// - Medium source enabled under same conditions
// - High ready flag while high source runs
// - High locked flag within 2 percent
// - High stable flag within half percent
// - Medium ready flag while medium source runs
// - Four-bit frequency select chooses postscaled output
// - Trim is six-bit signed, resets to zero
// - Trim applies to medium and high sources
// - Trim drifts gradually, no completion flag
// - Trim leaves low source untouched
// - Low source is untrimmed 31 kHz
// - Select: 00 config, 01 secondary, 1x internal
// - Reset loads frequency select with 0111
// - Switch: start, fall, hold low, rise, update status
// - Same-source frequency change has no start-up delay
package oscsel_pkg;
    // Boot clock mode codes
    localparam logic [1:0] OSCSEL_MODE_INTERNAL = 2'h0;
    localparam logic [1:0] OSCSEL_MODE_EXT_LOW = 2'h1;
    localparam logic [1:0] OSCSEL_MODE_EXT_MED = 2'h2;
    localparam logic [1:0] OSCSEL_MODE_EXT_HIGH = 2'h3;
    // Run-time select codes
    localparam logic [1:0] OSCSEL_SEL_CONFIG = 2'h0;
    localparam logic [1:0] OSCSEL_SEL_SECONDARY = 2'h1;
    // Reset values
    localparam logic [3:0] OSCSEL_FREQ_RESET = 4'h7;
    localparam logic [5:0] OSCSEL_TRIM_RESET = 6'h00;
    // Start-up delays in ns, converted at 50 MHz (20 ns)
    localparam int OSCSEL_CLK_NS = 20;
    localparam int OSCSEL_MF_START_NS = 2000;
    localparam int OSCSEL_HF_START_NS = 1000;
    localparam int OSCSEL_LF_START_NS = 2000;
    localparam int OSCSEL_HF_LOCK_NS = 1000;
    localparam int OSCSEL_HF_STABLE_NS = 2000;
    localparam int OSCSEL_TRIM_STEP_NS = 200;
    localparam logic [7:0] OSCSEL_MF_START_CYC = 8'((OSCSEL_MF_START_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    localparam logic [7:0] OSCSEL_HF_START_CYC = 8'((OSCSEL_HF_START_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    localparam logic [7:0] OSCSEL_LF_START_CYC = 8'((OSCSEL_LF_START_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    localparam logic [7:0] OSCSEL_HF_LOCK_CYC = 8'((OSCSEL_HF_LOCK_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    localparam logic [7:0] OSCSEL_HF_STABLE_CYC = 8'((OSCSEL_HF_STABLE_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    localparam logic [7:0] OSCSEL_TRIM_STEP_CYC = 8'((OSCSEL_TRIM_STEP_NS + OSCSEL_CLK_NS - 1) / OSCSEL_CLK_NS);
    // Internal source identifiers
    typedef enum logic [1:0] {
        OSCSEL_SRC_LF,
        OSCSEL_SRC_MF,
        OSCSEL_SRC_HF
    } oscsel_src_type;
    // Active system clock source
    typedef enum logic [2:0] {
        OSCSEL_SYS_EXT_LOW,
        OSCSEL_SYS_EXT_MED,
        OSCSEL_SYS_EXT_HIGH,
        OSCSEL_SYS_SECONDARY,
        OSCSEL_SYS_INTERNAL
    } oscsel_sys_type;
    // Frequency select code to source: 0-1 LF, 2-A MF (nine codes), B-F HF
    function automatic oscsel_src_type oscsel_code_src(input logic [3:0] code);
        oscsel_src_type s;
        s = OSCSEL_SRC_MF;
        case (code)
            4'h0, 4'h1: s = OSCSEL_SRC_LF;
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: s = OSCSEL_SRC_MF;
            4'hB, 4'hC, 4'hD, 4'hE, 4'hF: s = OSCSEL_SRC_HF;
            default: s = OSCSEL_SRC_MF;
        endcase
        return s;
    endfunction
endpackage

// ### hdl/oscsel_core.sv
// Oscillator source select: mode, PLL enable, source enables, switch sequencing, status and trim
`timescale 1ns/1ps
module oscsel_core (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clkEn,
    // Configuration word bits
    input wire logic [1:0] bootClockSourceSelect,
    input wire logic cfgPllForceEnable,
    input wire logic clkoutPinEnable,
    // Run-time control
    input wire logic [1:0] sysClockSelect,
    input wire logic swPllEnable,
    input wire logic [3:0] internalFreqSelectIn,
    input wire logic internalFreqSelectWr,
    input wire logic [5:0] oscTrimIn,
    input wire logic oscTrimWr,
    // External clock presence (generator running)
    input wire logic extClockRunning,
    // Status and selection outputs
    output logic [2:0] sysSource,
    output logic [3:0] activeFreqSelect,
    output logic [3:0] internalFreqSelect,
    output logic pllEnable,
    output logic hfOscEnable,
    output logic mfOscEnable,
    output logic lfOscEnable,
    output logic hfOscReady,
    output logic hfOscLocked,
    output logic hfOscStable,
    output logic mfOscReady,
    output logic lfOscReady,
    output logic [5:0] oscTrim,
    output logic [5:0] appliedTrim,
    output logic clkInPinIsGpio,
    output logic clkOutPinIsClock,
    output logic sysClockHeldLow,
    output logic switchBusy
);
    import oscsel_pkg::*;

    typedef enum {SW_IDLE, SW_START, SW_FALL, SW_RISE, SW_UPDATE} oscsel_sw_type;

    oscsel_sw_type swState_reg;
    oscsel_sys_type sys_next;
    oscsel_src_type reqSrc;
    oscsel_src_type curSrc;
    logic [3:0] freq_reg;
    logic [3:0] active_reg;
    logic [5:0] trim_reg;
    logic [5:0] applied_reg;
    logic [7:0] mfCnt_reg;
    logic [7:0] hfCnt_reg;
    logic [7:0] lfCnt_reg;
    logic [7:0] trimCnt_reg;
    logic internalSel;
    logic hfWant;
    logic mfWant;
    logic lfWant;
    logic newReady;

    // Internal block powered when boot mode is internal or select is 1x, even while select 01 runs
    assign internalSel = sysClockSelect[1] || bootClockSourceSelect == OSCSEL_MODE_INTERNAL;
    assign reqSrc = oscsel_code_src(freq_reg);
    assign curSrc = oscsel_code_src(active_reg);
    // HF depends on MF running through its PLL, so MF is kept on with it
    assign hfWant = internalSel && (reqSrc == OSCSEL_SRC_HF || curSrc == OSCSEL_SRC_HF);
    assign mfWant = internalSel && (reqSrc != OSCSEL_SRC_LF || curSrc != OSCSEL_SRC_LF);
    assign lfWant = internalSel && (reqSrc == OSCSEL_SRC_LF || curSrc == OSCSEL_SRC_LF);
    assign newReady = reqSrc == OSCSEL_SRC_HF ? hfOscReady :
                      reqSrc == OSCSEL_SRC_MF ? mfOscReady : lfOscReady;

    // Source decode from mode and run-time select
    always_comb begin
        sys_next = OSCSEL_SYS_INTERNAL;
        case (sysClockSelect)
            OSCSEL_SEL_CONFIG: begin
                case (bootClockSourceSelect)
                    OSCSEL_MODE_EXT_LOW: sys_next = OSCSEL_SYS_EXT_LOW;
                    OSCSEL_MODE_EXT_MED: sys_next = OSCSEL_SYS_EXT_MED;
                    OSCSEL_MODE_EXT_HIGH: sys_next = OSCSEL_SYS_EXT_HIGH;
                    default: sys_next = OSCSEL_SYS_INTERNAL;
                endcase
            end
            OSCSEL_SEL_SECONDARY: sys_next = OSCSEL_SYS_SECONDARY;
            default: sys_next = OSCSEL_SYS_INTERNAL;
        endcase
    end

    // System source follows select at once; external needs no start-up wait
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sysSource <= 3'h0;
        end else if (clkEn) begin
            sysSource <= 3'(sys_next);
        end
    end

    // PLL enable: config bit overrides run-time bit; run-time bit ignored with select 1x
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pllEnable <= 1'b0;
        end else if (clkEn) begin
            pllEnable <= cfgPllForceEnable || (swPllEnable && !sysClockSelect[1]);
        end
    end

    // Pin roles; external clock pin stays clock input in external modes unless select is 1x
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clkInPinIsGpio <= 1'b0;
            clkOutPinIsClock <= 1'b0;
        end else if (clkEn) begin
            clkInPinIsGpio <= internalSel;
            clkOutPinIsClock <= clkoutPinEnable;
        end
    end

    // Frequency select register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            freq_reg <= OSCSEL_FREQ_RESET;
        end else if (clkEn && internalFreqSelectWr) begin
            freq_reg <= internalFreqSelectIn;
        end
    end

    // Trim register, signed, reset to zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            trim_reg <= OSCSEL_TRIM_RESET;
        end else if (clkEn && oscTrimWr) begin
            trim_reg <= oscTrimIn;
        end
    end

    // Applied trim walks one step at a time toward the target; nothing reports arrival
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            applied_reg <= OSCSEL_TRIM_RESET;
            trimCnt_reg <= 8'h00;
        end else if (clkEn) begin
            if (applied_reg == trim_reg) begin
                trimCnt_reg <= 8'h00;
            end else if (trimCnt_reg >= OSCSEL_TRIM_STEP_CYC - 8'h01) begin
                trimCnt_reg <= 8'h00;
                if ($signed(applied_reg) < $signed(trim_reg)) begin
                    applied_reg <= applied_reg + 6'h01;
                end else begin
                    applied_reg <= applied_reg - 6'h01;
                end
            end else begin
                trimCnt_reg <= trimCnt_reg + 8'h01;
            end
        end
    end

    // MF start-up; trim acts on MF and through it on HF, never on LF
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mfCnt_reg <= 8'h00;
        end else if (clkEn) begin
            if (!mfWant) begin
                mfCnt_reg <= 8'h00;
            end else if (mfCnt_reg < OSCSEL_MF_START_CYC) begin
                mfCnt_reg <= mfCnt_reg + 8'h01;
            end
        end
    end

    // HF start-up, lock and settle counted after MF is ready; a trim step knocks it back to locked
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hfCnt_reg <= 8'h00;
        end else if (clkEn) begin
            if (!hfWant || !mfOscReady) begin
                hfCnt_reg <= 8'h00;
            end else if (applied_reg != trim_reg && hfCnt_reg > OSCSEL_HF_START_CYC + OSCSEL_HF_LOCK_CYC) begin
                hfCnt_reg <= OSCSEL_HF_START_CYC + OSCSEL_HF_LOCK_CYC;
            end else if (hfCnt_reg < OSCSEL_HF_START_CYC + OSCSEL_HF_LOCK_CYC + OSCSEL_HF_STABLE_CYC) begin
                hfCnt_reg <= hfCnt_reg + 8'h01;
            end
        end
    end

    // LF start-up, independent of trim
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lfCnt_reg <= 8'h00;
        end else if (clkEn) begin
            if (!lfWant) begin
                lfCnt_reg <= 8'h00;
            end else if (lfCnt_reg < OSCSEL_LF_START_CYC) begin
                lfCnt_reg <= lfCnt_reg + 8'h01;
            end
        end
    end

    // Enables and status flags, registered
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hfOscEnable <= 1'b0;
            mfOscEnable <= 1'b0;
            lfOscEnable <= 1'b0;
            hfOscReady <= 1'b0;
            hfOscLocked <= 1'b0;
            hfOscStable <= 1'b0;
            mfOscReady <= 1'b0;
            lfOscReady <= 1'b0;
        end else if (clkEn) begin
            hfOscEnable <= hfWant;
            mfOscEnable <= mfWant;
            lfOscEnable <= lfWant;
            hfOscReady <= hfWant && hfCnt_reg >= OSCSEL_HF_START_CYC;
            hfOscLocked <= hfWant && hfCnt_reg >= OSCSEL_HF_START_CYC + OSCSEL_HF_LOCK_CYC;
            hfOscStable <= hfWant
                && hfCnt_reg >= OSCSEL_HF_START_CYC + OSCSEL_HF_LOCK_CYC + OSCSEL_HF_STABLE_CYC;
            mfOscReady <= mfWant && mfCnt_reg >= OSCSEL_MF_START_CYC;
            lfOscReady <= lfWant && lfCnt_reg >= OSCSEL_LF_START_CYC;
        end
    end

    // Switch sequencer: wait for new source, then fall, hold low, rise, update
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            swState_reg <= SW_IDLE;
            active_reg <= OSCSEL_FREQ_RESET;
            sysClockHeldLow <= 1'b0;
        end else if (clkEn) begin
            case (swState_reg)
                SW_IDLE: begin
                    if (freq_reg != active_reg) begin
                        // Same source: skip start-up wait
                        swState_reg <= reqSrc == curSrc ? SW_FALL : SW_START;
                    end
                end
                SW_START: begin
                    // Unpowered block has no source to wait for, so the switch cannot hang
                    if (newReady || !internalSel) begin
                        swState_reg <= SW_FALL;
                    end
                end
                SW_FALL: begin
                    sysClockHeldLow <= 1'b1;
                    swState_reg <= SW_RISE;
                end
                SW_RISE: begin
                    sysClockHeldLow <= 1'b0;
                    active_reg <= freq_reg;
                    swState_reg <= SW_UPDATE;
                end
                SW_UPDATE: begin
                    swState_reg <= SW_IDLE;
                end
                default: swState_reg <= SW_IDLE;
            endcase
        end
    end

    // Registered copies of the select and trim fields
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            internalFreqSelect <= OSCSEL_FREQ_RESET;
            activeFreqSelect <= OSCSEL_FREQ_RESET;
            oscTrim <= OSCSEL_TRIM_RESET;
            appliedTrim <= OSCSEL_TRIM_RESET;
            switchBusy <= 1'b0;
        end else if (clkEn) begin
            internalFreqSelect <= freq_reg;
            activeFreqSelect <= active_reg;
            oscTrim <= trim_reg;
            appliedTrim <= applied_reg;
            switchBusy <= swState_reg != SW_IDLE || freq_reg != active_reg;
        end
    end

    // extClockRunning only documents the stall; logic freezes via clkEn
    logic unusedExt;
    assign unusedExt = extClockRunning;
endmodule // oscsel_core

// ### tb/oscsel_core_assertions.sv
// Concurrent checks on the ports of the oscillator source select core
`timescale 1ns/1ps
module oscsel_core_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Watched inputs
    input wire logic clkEn,
    input wire logic [1:0] bootClockSourceSelect,
    input wire logic cfgPllForceEnable,
    input wire logic clkoutPinEnable,
    input wire logic [1:0] sysClockSelect,
    input wire logic swPllEnable,
    input wire logic [5:0] oscTrimIn,
    input wire logic oscTrimWr,
    // Watched outputs
    input wire logic [2:0] sysSource,
    input wire logic [3:0] internalFreqSelect,
    input wire logic pllEnable,
    input wire logic hfOscReady,
    input wire logic hfOscLocked,
    input wire logic hfOscStable,
    input wire logic [5:0] oscTrim,
    input wire logic clkInPinIsGpio,
    input wire logic clkOutPinIsClock,
    input wire logic sysClockHeldLow,
    input wire logic switchBusy
);
    // One clock domain, so clocking and disable are set once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_pll_forced: assert property (clkEn && cfgPllForceEnable |=> pllEnable)
        else $error("pll off while forced");
    a_pll_soft_bit: assert property (clkEn && !cfgPllForceEnable && sysClockSelect == 2'h0
        |=> pllEnable == $past(swPllEnable)) else $error("pll does not follow run-time bit");
    a_src_config: assert property (clkEn && sysClockSelect == 2'h0 && bootClockSourceSelect != 2'h0
        |=> sysSource + 3'h1 == {1'b0, $past(bootClockSourceSelect)}) else $error("wrong external source");
    a_src_internal: assert property (clkEn && sysClockSelect[1] |=> sysSource == 3'h4 && clkInPinIsGpio)
        else $error("internal block not selected");
    a_clock_output_pin_role: assert property (clkEn && sysClockSelect[1]
        |=> clkOutPinIsClock == $past(clkoutPinEnable)) else $error("clock output role wrong");
    a_trim_load: assert property (clkEn && oscTrimWr ##1 (clkEn && !oscTrimWr)[*3]
        |-> oscTrim == $past(oscTrimIn, 3)) else $error("trim not stored");
    a_hf_flags: assert property (hfOscStable |-> hfOscLocked && hfOscReady)
        else $error("hf stable without lock");
    a_held_pulse: assert property (sysClockHeldLow && clkEn |=> !sysClockHeldLow)
        else $error("clock held low too long");
    a_held_busy: assert property (sysClockHeldLow |-> switchBusy)
        else $error("held low outside a switch");
    a_freeze_state: assert property (!clkEn
        |=> $stable(oscTrim) && $stable(internalFreqSelect) && $stable(sysSource)) else $error("state moved");
    // Main scenarios reached
    c_switch: cover property (sysClockHeldLow);
    c_hf_stable: cover property (hfOscStable);
    c_pll_forced: cover property (pllEnable && cfgPllForceEnable);
endmodule // oscsel_core_assertions

bind oscsel_core oscsel_core_assertions u_chk (.mclk, .rstn, .clkEn, .bootClockSourceSelect,
    .cfgPllForceEnable, .clkoutPinEnable, .sysClockSelect, .swPllEnable, .oscTrimIn, .oscTrimWr,
    .sysSource, .internalFreqSelect, .pllEnable, .hfOscReady, .hfOscLocked, .hfOscStable, .oscTrim,
    .clkInPinIsGpio, .clkOutPinIsClock, .sysClockHeldLow, .switchBusy);

// ### tb/oscsel_ext_clk.sv
// Behavioural external clock generator on the clock input pin
`timescale 1ns/1ps
module oscsel_ext_clk (
    // Reference and stop request
    input wire logic mclk,
    input wire logic stopReq,
    // Generator state seen by the device
    output logic running,
    output logic clkEn
);
    // Generator drives the pin at a rate inside the chosen band
    initial running = 1'b1;
    // Stops land on whole cycles so no runt edge reaches the core
    always @(negedge mclk) running <= !stopReq;
    assign clkEn = running;
endmodule // oscsel_ext_clk

// ### tb/testbench.sv
// Self-checking bench for the oscillator source select core
`timescale 1ns/1ps
module testbench;
    import oscsel_pkg::*;
    // Stimulus
    logic mclk = 1'b0, rstn = 1'b0, stopReq = 1'b0, clkEn, extRun, sawHeld = 1'b0;
    logic [1:0] bootClockSourceSelect = 2'h0, sysClockSelect = 2'h0;
    logic cfgPllForceEnable = 1'b0, clkoutPinEnable = 1'b0, swPllEnable = 1'b0;
    logic [3:0] internalFreqSelectIn = 4'h7;
    logic internalFreqSelectWr = 1'b0, oscTrimWr = 1'b0;
    logic [5:0] oscTrimIn = 6'h00;
    // Observed
    logic [2:0] sysSource;
    logic [3:0] activeFreqSelect, internalFreqSelect;
    logic pllEnable, hfOscEnable, mfOscEnable, lfOscEnable, hfOscReady, hfOscLocked, hfOscStable;
    logic mfOscReady, lfOscReady, clkInPinIsGpio, clkOutPinIsClock, sysClockHeldLow, switchBusy;
    logic [5:0] oscTrim, appliedTrim;
    int err_total = 0;
    int samples_checked = 0;
    always #10 mclk = ~mclk;
    oscsel_ext_clk u_gen (.mclk, .stopReq, .running(extRun), .clkEn);
    oscsel_core uut (.mclk, .rstn, .clkEn, .bootClockSourceSelect, .cfgPllForceEnable, .clkoutPinEnable,
        .sysClockSelect, .swPllEnable, .internalFreqSelectIn, .internalFreqSelectWr, .oscTrimIn, .oscTrimWr,
        .extClockRunning(extRun), .sysSource, .activeFreqSelect, .internalFreqSelect, .pllEnable,
        .hfOscEnable, .mfOscEnable, .lfOscEnable, .hfOscReady, .hfOscLocked, .hfOscStable, .mfOscReady,
        .lfOscReady, .oscTrim, .appliedTrim, .clkInPinIsGpio, .clkOutPinIsClock, .sysClockHeldLow,
        .switchBusy);
    // Sticky record that the output was parked low during a switch
    always @(posedge mclk) if (sysClockHeldLow === 1'b1) sawHeld <= 1'b1;
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_val({7'h00, got}, {7'h00, exp});
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Write a frequency code and count cycles until it becomes active
    task automatic write_freq(input logic [3:0] c, input int lim, output int n);
        internalFreqSelectIn = c;
        internalFreqSelectWr = 1'b1;
        step(1);
        internalFreqSelectWr = 1'b0;
        for (n = 0; n < lim && activeFreqSelect !== c; n++) step(1);
    endtask
    task automatic write_trim(input logic [5:0] t);
        oscTrimIn = t;
        oscTrimWr = 1'b1;
        step(1);
        oscTrimWr = 1'b0;
        step(3);
    endtask
    // Expected system source for a select and boot mode
    function automatic logic [2:0] exp_src(input logic [1:0] s, input logic [1:0] b);
        if (s[1]) return 3'h4;
        if (s == 2'h1) return 3'h3;
        return (b == 2'h0) ? 3'h4 : {1'b0, b} - 3'h1;
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog sized well above the expected run of a few thousand cycles
    initial begin
        #400000;
        err_total++;
        finish_test;
    end
    initial begin
        int n;
        logic [5:0] t;
        logic [3:0] c;
        logic lf0;
        void'($urandom(32'hB5F66455));
        step(12);
        rstn = 1'b1;
        step(1);
        check_val(internalFreqSelect, 8'h07);
        check_val(oscTrim, 8'h00);
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 4; b++) begin
                sysClockSelect = 2'(s);
                bootClockSourceSelect = 2'(b);
                step(2);
                check_val(sysSource, exp_src(2'(s), 2'(b)));
            end
        end
        for (int i = 0; i < 8; i++) begin
            cfgPllForceEnable = i[0];
            swPllEnable = i[1];
            sysClockSelect = i[2] ? 2'h2 : 2'h0;
            step(2);
            check_flag(pllEnable, i[0] | (i[1] & !i[2]));
        end
        cfgPllForceEnable = 1'b0;
        swPllEnable = 1'b0;
        for (int e = 0; e < 2; e++) begin
            clkoutPinEnable = e[0];
            step(2);
            check_flag(clkInPinIsGpio, 1'b1);
            check_flag(clkOutPinIsClock, e[0]);
        end
        for (n = 0; n < 300 && mfOscReady !== 1'b1; n++) step(1);
        check_flag(mfOscEnable, 1'b1);
        check_flag(mfOscReady, 1'b1);
        sawHeld = 1'b0;
        write_freq(4'h6, 40, n);
        check_flag(n < 8, 1'b1);
        check_flag(sawHeld, 1'b1);
        // Random medium-source codes, never the one already active
        repeat (4) begin
            c = 4'(2 + $urandom_range(8));
            if (c === activeFreqSelect) c = (c == 4'h2) ? 4'h3 : 4'h2;
            write_freq(c, 40, n);
            check_flag(n < 8, 1'b1);
            check_val(internalFreqSelect, c);
        end
        write_freq(4'hF, 400, n);
        check_flag(n > 20, 1'b1);
        check_flag(hfOscEnable, 1'b1);
        check_flag(hfOscReady, 1'b1);
        check_flag(mfOscReady, 1'b1);
        for (n = 0; n < 400 && hfOscStable !== 1'b1; n++) step(1);
        check_flag(hfOscStable, 1'b1);
        check_flag(hfOscLocked, 1'b1);
        // Cross to the low source: HF and MF shut down once it is active
        write_freq(4'h0, 400, n);
        check_flag(n > 20, 1'b1);
        check_flag(lfOscEnable, 1'b1);
        check_flag(lfOscReady, 1'b1);
        check_flag(hfOscEnable, 1'b0);
        check_flag(mfOscEnable, 1'b0);
        lf0 = lfOscReady;
        for (int k = 0; k < 3; k++) begin
            t = (k == 0) ? 6'h1F : (k == 1) ? 6'h20 : 6'($urandom);
            write_trim(t);
            check_val(oscTrim, t);
            for (n = 0; n < 1000 && appliedTrim !== t; n++) step(1);
            check_val(appliedTrim, t);
            check_flag(lfOscReady, lf0);
        end
        // Stopped generator: a trim write must be lost, state kept
        stopReq = 1'b1;
        step(2);
        write_trim(~t);
        step(8);
        check_val(oscTrim, t);
        stopReq = 1'b0;
        step(3);
        check_val(activeFreqSelect, 8'h00);
        rstn = 1'b0;
        step(2);
        rstn = 1'b1;
        step(1);
        check_val(internalFreqSelect, 8'h07);
        check_val(oscTrim, 8'h00);
        finish_test;
    end
endmodule // testbench
